// file: shared/sar_cfg.svh
/*
 file holds: offsets, field positions, reset values and counts of the
 converter control block.
 assumes: included by bare name wherever a value is needed.
*/
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH

`define SAR_ADDR_CTRL 8'h00
`define SAR_ADDR_RANGE 8'h04
`define SAR_ADDR_RESULT 8'h08
`define SAR_ADDR_STATUS 8'h0C
`define SAR_ADDR_LSB 8'h10

`define SAR_CTRL_MODE_LSB 0
`define SAR_CTRL_REF_BIT 2
`define SAR_CTRL_CODING_BIT 3
`define SAR_CTRL_PD_LSB 4
`define SAR_CTRL_CHAN_LSB 6
`define SAR_CTRL_SEQ_BIT 9
`define SAR_CTRL_RESET 10'h000
`define SAR_RANGE_RESET 16'h0000

`define SAR_STAT_BUSY_BIT 8
`define SAR_STAT_OVR_BIT 9
`define SAR_STAT_FULL_BIT 10
`define SAR_RES_VALID_BIT 31

`define SAR_CODE_BITS 13
`define SAR_CODE_SPAN 8192
`define SAR_SIGN_MASK 13'h1000
`define SAR_MSB_INDEX 4'hC
`define SAR_LAST_DECIDE 4'hD
`define SAR_TRACK_EDGE 4'hE
`define SAR_FIFO_DEPTH 16
`define SAR_FIFO_WIDTH 16

`define SAR_LSB_NV_10B 32'h0025_40BE
`define SAR_LSB_NV_5B 32'h0012_A05F
`define SAR_LSB_NV_2B 32'h0009_502F
`define SAR_LSB_NV_10U 32'h0012_A05F

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// file: shared/sar_pkg.sv
/*
 file holds: types of the converter control block.
 assumes: nothing beyond the compiler.
*/
package sar_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_TAIL = 2'b11
    } state_t;

    typedef enum logic [1:0] {
        IN_SINGLE_8 = 2'b00,
        IN_DIFF_4 = 2'b01,
        IN_PSEUDO_4 = 2'b10,
        IN_PSEUDO_7 = 2'b11
    } in_mode_t;

    typedef enum logic [1:0] {
        RNG_BIP_10 = 2'b00,
        RNG_BIP_5 = 2'b01,
        RNG_BIP_2P5 = 2'b10,
        RNG_UNI_10 = 2'b11
    } range_t;
endpackage

// file: shared/stream_if.sv
/*
 file holds: valid/ready word carrier between the block's modules.
 assumes: both ends on the same clock.
*/
interface stream_if #(parameter int W = 16) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: src/result_fifo.sv
/*
 file holds: flip-flop FIFO with valid/ready on both sides.
 assumes: one clock, synchronous active-low reset, clock enable.
*/
module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    stream_if.snk wr,
    stream_if.src rd,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    wire push = wr.valid && wr.ready;
    wire pop = rd.valid && rd.ready;
    wire full = count == (AW+1)'(DEPTH);

    assign wr.ready = !full;
    assign rd.valid = count != '0;
    assign rd.data = mem[rptr];

    always_ff @(posedge aclk)
    begin
        if (ce && push)
        begin
            mem[wptr] <= wr.data;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end
        else if (ce)
        begin
            if (push)
                wptr <= wptr + 1'b1;
            if (pop)
                rptr <= rptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // result_fifo

// file: src/sar_adc_control_config.sv
/*
 file holds: control, configuration and successive approximation
 sequencing of the eight-channel 13-bit converter, with an AXI4-Lite
 register slave and a result FIFO.
 assumes: sclk, cs_n and the comparator arrive asynchronously and are
 synchronised; sclk stays below a quarter of aclk.
*/
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`include "sar_cfg.svh"

// Notes on behaviour
// - each conversion yields a 13-bit code, twelve magnitude bits and sign.
// - a conversion needs only fourteen serial clock edges, for high throughput.
// - every channel keeps its own two-bit input range in the range register.
// - two mode bits choose single-ended, differential or pseudo differential.
// - after reset inputs are eight single-ended; host must write to change.
// - the first thirteen rising serial clock edges both step the conversion and shift the data out.
// - after reset external reference; host sets the reference bit for internal.
// - power-down setting from the control register applies between conversions.
// - output coding is twos complement after reset.
// - coding bit set gives straight binary results.
// - sequenced channels all use the coding from the latest control write.
// - one code step is the selected span over 8192 codes.
// - result resolved bit by bit from comparator, driving the trial DAC code.
// - sampling returns to track after the fourteenth rising serial clock edge.
// - falling chip select puts sampling into hold and starts a conversion.
// - twos complement maps the span to codes -4096 to +4095.
module sar_adc_control_config (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic comp_in,
    output logic dout,
    output logic hold,
    output logic [12:0] dac_code,
    output logic [2:0] mux_chan,
    output logic [1:0] in_mode,
    output logic [1:0] chan_range,
    output logic ref_internal,
    output logic [1:0] pd_mode
);
    // synchronisers
    logic sclk_s1, sclk_s2, sclk_s3;
    logic cs_s1, cs_s2, cs_s3;
    logic comp_s1, comp_s2;

    // configuration
    logic [9:0] ctrl;
    logic [15:0] range_reg;
    logic overrun;

    // conversion
    sar_pkg::state_t state;
    logic [3:0] edge_cnt;
    logic [3:0] bit_idx;
    logic [12:0] sar;
    logic [2:0] seq_ptr;
    logic [15:0] pend_data;
    logic pend_valid;

    // fifo
    stream_if #(.W(`SAR_FIFO_WIDTH)) fin ();
    stream_if #(.W(`SAR_FIFO_WIDTH)) fout ();
    logic [4:0] fifo_count;

    function automatic logic [12:0] sar_step(input logic [12:0] cur,
        input logic [3:0] b, input logic keep);
        logic [12:0] nxt;
        nxt = cur;
        nxt[b] = keep;
        if (b != 4'h0)
            nxt[b - 4'h1] = 1'b1;
        return nxt;
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old,
        input logic [31:0] val, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                res[i*8 +: 8] = val[i*8 +: 8];
        return res;
    endfunction

    function automatic logic [31:0] lsb_nv(input logic [1:0] rng);
        unique case (sar_pkg::range_t'(rng))
            sar_pkg::RNG_BIP_10: return `SAR_LSB_NV_10B;
            sar_pkg::RNG_BIP_5: return `SAR_LSB_NV_5B;
            sar_pkg::RNG_BIP_2P5: return `SAR_LSB_NV_2B;
            sar_pkg::RNG_UNI_10: return `SAR_LSB_NV_10U;
        endcase
    endfunction

    // decoding
    wire sclk_rise = sclk_s2 && !sclk_s3;
    wire cs_fall = !cs_s2 && cs_s3;
    wire cs_rise = cs_s2 && !cs_s3;
    wire coding_bin = ctrl[`SAR_CTRL_CODING_BIT];
    wire seq_en = ctrl[`SAR_CTRL_SEQ_BIT];
    wire [2:0] chan_sel = ctrl[`SAR_CTRL_CHAN_LSB +: 3];
    wire in_conv = state == sar_pkg::ST_CONV;
    wire decide = in_conv && sclk_rise && edge_cnt < `SAR_LAST_DECIDE;
    wire track_edge = in_conv && sclk_rise
        && edge_cnt == `SAR_LAST_DECIDE;
    wire [12:0] next_sar = sar_step(sar, bit_idx, comp_s2);
    // straight binary is the raw sar code, twos complement flips the sign
    wire [12:0] coded = coding_bin ? sar
        : sar ^ `SAR_SIGN_MASK;
    wire next_dout = comp_s2 ^ (bit_idx == `SAR_MSB_INDEX
        && !coding_bin);
    wire [2:0] next_chan = seq_en ? seq_ptr : chan_sel;
    wire [2:0] next_seq = (seq_ptr >= chan_sel) ? 3'h0 : seq_ptr + 3'h1;

    // register bus decode
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    wire wr_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire wr_ctrl = wr_do && wr_addr == `SAR_ADDR_CTRL;
    wire wr_range = wr_do && wr_addr == `SAR_ADDR_RANGE;
    wire wr_stat = wr_do && wr_addr == `SAR_ADDR_STATUS;
    wire wr_ok = wr_ctrl || wr_range || wr_stat;
    wire [31:0] ctrl_merged = strb_merge({22'h0, ctrl}, wr_data, wr_strb);
    wire [31:0] range_merged = strb_merge({16'h0, range_reg}, wr_data,
        wr_strb);
    wire ovr_clear = wr_stat && wr_strb[1]
        && wr_data[`SAR_STAT_OVR_BIT];
    wire rd_result = s_axi_araddr == `SAR_ADDR_RESULT;
    wire rd_ok = s_axi_araddr == `SAR_ADDR_CTRL
        || s_axi_araddr == `SAR_ADDR_RANGE || rd_result
        || s_axi_araddr == `SAR_ADDR_STATUS
        || s_axi_araddr == `SAR_ADDR_LSB;
    wire [31:0] stat_word = {21'h0, fifo_count == 5'(`SAR_FIFO_DEPTH),
        overrun, state != sar_pkg::ST_IDLE, 3'h0, fifo_count};
    wire [31:0] result_word = fout.valid ? {1'b1, 15'h0, fout.data}
        : 32'h0000_0000;
    wire [31:0] rd_word =
        s_axi_araddr == `SAR_ADDR_CTRL ? {22'h0, ctrl} :
        s_axi_araddr == `SAR_ADDR_RANGE ? {16'h0, range_reg} :
        rd_result ? result_word :
        s_axi_araddr == `SAR_ADDR_STATUS ? stat_word :
        s_axi_araddr == `SAR_ADDR_LSB ? lsb_nv(chan_range) :
        32'h0000_0000;

    assign fin.valid = pend_valid;
    assign fin.data = pend_data;
    assign fout.ready = ar_hs && rd_result;

    result_fifo #(
        .WIDTH(`SAR_FIFO_WIDTH),
        .DEPTH(`SAR_FIFO_DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .wr(fin),
        .rd(fout),
        .count(fifo_count)
    );

    // pin synchronisers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
            {cs_s1, cs_s2, cs_s3} <= 3'h7;
            {comp_s1, comp_s2} <= 2'h0;
        end
        else if (ce)
        begin
            {sclk_s1, sclk_s2, sclk_s3} <= {sclk, sclk_s1, sclk_s2};
            {cs_s1, cs_s2, cs_s3} <= {cs_n, cs_s1, cs_s2};
            {comp_s1, comp_s2} <= {comp_in, comp_s1};
        end
    end

    // frame state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state <= sar_pkg::ST_IDLE;
        else if (ce)
        begin
            unique case (state)
                sar_pkg::ST_IDLE:
                    if (cs_fall)
                        state <= sar_pkg::ST_CONV;
                sar_pkg::ST_CONV:
                    if (cs_rise)
                        state <= sar_pkg::ST_IDLE;
                    else if (track_edge)
                        state <= sar_pkg::ST_TAIL;
                sar_pkg::ST_TAIL:
                    if (cs_rise)
                        state <= sar_pkg::ST_IDLE;
                default:
                    state <= sar_pkg::ST_IDLE;
            endcase
        end
    end

    // successive approximation datapath
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            edge_cnt <= 4'h0;
            bit_idx <= 4'h0;
            sar <= 13'h0000;
            dout <= 1'b0;
            hold <= 1'b0;
            mux_chan <= 3'h0;
            seq_ptr <= 3'h0;
        end
        else if (ce)
        begin
            hold <= state == sar_pkg::ST_IDLE ? cs_fall
                : in_conv && !cs_rise && !track_edge;
            if (state == sar_pkg::ST_IDLE && cs_fall)
            begin
                edge_cnt <= 4'h0;
                bit_idx <= `SAR_MSB_INDEX;
                sar <= `SAR_SIGN_MASK;
                mux_chan <= next_chan;
            end
            else if (decide)
            begin
                edge_cnt <= edge_cnt + 4'h1;
                sar <= next_sar;
                dout <= next_dout;
                if (bit_idx != 4'h0)
                    bit_idx <= bit_idx - 4'h1;
            end
            else if (track_edge)
            begin
                edge_cnt <= `SAR_TRACK_EDGE;
                if (seq_en)
                    seq_ptr <= next_seq;
            end
        end
    end

    // result hand-off, holds one word on a full fifo and drops the next result with overrun
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pend_valid <= 1'b0;
            pend_data <= 16'h0000;
            overrun <= 1'b0;
        end
        else if (ce)
        begin
            if (fin.valid && fin.ready)
                pend_valid <= 1'b0;
            if (track_edge && pend_valid && !fin.ready)
                overrun <= 1'b1;
            else if (ovr_clear)
                overrun <= 1'b0;
            if (track_edge && !(pend_valid && !fin.ready))
            begin
                pend_valid <= 1'b1;
                // code as left by the last decision edge, taken at the track edge
                pend_data <= {mux_chan, coded};
            end
        end
    end

    // configuration and pin drive
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl <= `SAR_CTRL_RESET;
            range_reg <= `SAR_RANGE_RESET;
            in_mode <= 2'h0;
            ref_internal <= 1'b0;
            pd_mode <= 2'h0;
            chan_range <= 2'h0;
            dac_code <= 13'h0000;
        end
        else if (ce)
        begin
            if (wr_ctrl)
                ctrl <= ctrl_merged[9:0];
            if (wr_range)
                range_reg <= range_merged[15:0];
            in_mode <= ctrl[`SAR_CTRL_MODE_LSB +: 2];
            ref_internal <= ctrl[`SAR_CTRL_REF_BIT];
            pd_mode <= state == sar_pkg::ST_IDLE
                ? ctrl[`SAR_CTRL_PD_LSB +: 2] : 2'h0;
            chan_range <= range_reg[mux_chan*2 +: 2];
            dac_code <= in_conv ? sar : 13'h0000;
        end
    end

    // AXI4-Lite write channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_RESP_OKAY;
            wr_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end
        else if (ce)
        begin
            if (aw_hs)
            begin
                s_axi_awready <= 1'b0;
                wr_addr <= s_axi_awaddr;
            end
            if (w_hs)
            begin
                s_axi_wready <= 1'b0;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (wr_do)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AXI_RESP_OKAY;
        end
        else if (ce)
        begin
            if (ar_hs)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // sar_adc_control_config

// file: tb/sar_ctl_sva.sv
/*
 holds: concurrent checks on the converter control block's ports.
 assumes: bound to the top module from the bench's top file.
*/
module sar_ctl_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic hold,
    input wire logic [12:0] dac_code,
    input wire logic [1:0] pd_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // cycles since the serial clock last rose, saturating
    logic [3:0] since;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || $rose(sclk))
            since <= 4'h0;
        else if (since != 4'hF)
            since <= since + 4'h1;
    end

    property p_hold_start;
        $fell(cs_n) && !hold |-> ##[2:6] hold;
    endproperty
    a_hold_start: assert property (p_hold_start)
        else $error("hold not entered after chip select fell");
    property p_hold_code;
        $rose(hold) |=> dac_code == 13'h1000;
    endproperty
    a_hold_code: assert property (p_hold_code)
        else $error("first trial code is not the top bit");
    property p_track;
        $rose(cs_n) |-> ##[1:6] !hold;
    endproperty
    a_track: assert property (p_track)
        else $error("sampling did not return to track");
    property p_pd_run;
        hold && $past(hold) |-> pd_mode == 2'h0;
    endproperty
    a_pd_run: assert property (p_pd_run)
        else $error("power-down active during a frame");
    property p_dac_step;
        hold && $past(hold, 2) && $changed(dac_code)
            |-> since >= 4'h1 && since <= 4'h7;
    endproperty
    a_dac_step: assert property (p_dac_step)
        else $error("trial code moved without a serial clock edge");
    property p_dac_idle;
        !hold && !$past(hold) |-> dac_code == 13'h0000;
    endproperty
    a_dac_idle: assert property (p_dac_idle)
        else $error("trial code not cleared while tracking");
    property p_ar_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_ar_answer: assert property (p_ar_answer)
        else $error("read not answered one cycle after address");
    property p_b_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
    endproperty
    a_b_done: assert property (p_b_done)
        else $error("write response not retired");
    property p_err_zero;
        s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0000_0000;
    endproperty
    a_err_zero: assert property (p_err_zero)
        else $error("error read returned nonzero data");
endmodule // sar_ctl_sva

// file: tb/serial_host.sv
/*
 holds: serial host framing conversions, plus a comparator model.
 assumes: frame is called from the bench just after an aclk edge.
*/
module serial_host (
    input wire logic aclk,
    input wire logic [12:0] dac_code,
    output logic sclk,
    output logic cs_n,
    output logic comp_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] target = 13'h0000;
    initial sclk = 1'b0;
    initial cs_n = 1'b1;
    // keep the trial bit while the input is at or above it
    assign comp_in = dac_code <= target;

    // serial clock stands low outside frames
    task automatic frame(input logic [12:0] t, input int edges);
        @(posedge aclk);
        target <= t;
        cs_n <= 1'b0;
        repeat (8) @(posedge aclk);
        repeat (edges)
        begin
            sclk <= 1'b1;
            repeat (4) @(posedge aclk);
            sclk <= 1'b0;
            repeat (4) @(posedge aclk);
        end
        cs_n <= 1'b1;
        repeat (8) @(posedge aclk);
    endtask
endmodule // serial_host

// file: tb/sar_adc_control_config_tb_top.sv
/*
 holds: self-checking bench of the converter control block.
 assumes: serial_host and sar_ctl_sva compiled before it.
*/
`include "sar_cfg.svh"

module sar_adc_control_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] e;
        logic [31:0] m;
        logic [1:0] r;
    } note_t;
    note_t notes[$];
    note_t n;
    logic [1:0] bnotes[$];
    int seed = 35;
    int miscompares = 0;
    int n_tests = 0;
    int i;
    logic [31:0] rng;
    logic [12:0] t;
    logic [31:0] lsb [4] = '{`SAR_LSB_NV_10B, `SAR_LSB_NV_5B,
        `SAR_LSB_NV_2B, `SAR_LSB_NV_10U};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, sclk, cs_n, comp_in, dout, hold, ref_internal;
    logic [1:0] s_axi_bresp, s_axi_rresp, in_mode, chan_range, pd_mode;
    logic [31:0] s_axi_rdata;
    logic [12:0] dac_code;
    logic [2:0] mux_chan;

    sar_adc_control_config dut_u (.aclk, .aresetn, .ce, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sclk,
        .cs_n, .comp_in, .dout, .hold, .dac_code, .mux_chan, .in_mode,
        .chan_range, .ref_internal, .pd_mode);
    serial_host host_u (.aclk, .dac_code, .sclk, .cs_n, .comp_in);

    always #12.5 aclk = ~aclk;

    task automatic check(input string nm, input logic [31:0] s,
        input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] br = `AXI_RESP_OKAY);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        bnotes.push_back(br);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            ad = ad || s_axi_awready;
            wd = wd || s_axi_wready;
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !wd;
        end
        do
            @(posedge aclk);
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    // note the expectation, the monitor compares the answer
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m, input logic [1:0] r);
        notes.push_back({e, m, r});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
            @(posedge aclk);
        while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do
            @(posedge aclk);
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready)
        begin
            n = notes.pop_front();
            check("rdata", s_axi_rdata & n.m, n.e & n.m);
            check("rresp", 32'(s_axi_rresp), 32'(n.r));
        end
        if (s_axi_bvalid && s_axi_bready)
            check("bresp", 32'(s_axi_bresp), 32'(bnotes.pop_front()));
    end

    task automatic stop_test();
        $display("checks %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge aclk);
        miscompares++;
        stop_test();
    end

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`SAR_ADDR_CTRL, 32'h0, 32'h3FF, `AXI_RESP_OKAY);
        rd(`SAR_ADDR_RANGE, 32'h0, 32'hFFFF, `AXI_RESP_OKAY);
        rd(8'h20, 32'h0, 32'hFFFF_FFFF, `AXI_RESP_SLVERR);
        wr(8'h20, 32'hFFFF_FFFF, `AXI_RESP_SLVERR);
        check("in_mode", 32'(in_mode), 32'h0);
        check("ref_internal", 32'(ref_internal), 32'h0);
        for (i = 0; i < 4; i++)
        begin
            wr(`SAR_ADDR_CTRL, 32'(i) | 32'(i << 4) | 32'(i % 2 << 2));
            repeat (2) @(posedge aclk);
            check("in_mode", 32'(in_mode), 32'(i));
            check("pd_mode", 32'(pd_mode), 32'(i));
            check("ref_internal", 32'(ref_internal), 32'(i % 2));
        end
        rng = $random(seed);
        wr(`SAR_ADDR_RANGE, rng & 32'h0000_FFFF);
        for (i = 0; i < 8; i++)
        begin
            t = 13'($random(seed));
            if (i < 2)
                t = 13'h0000;
            if (i > 5)
                t = 13'h1FFF;
            wr(`SAR_ADDR_CTRL, 32'(i << 6) | 32'(i % 2 << 3));
            host_u.frame(t, 14);
            check("dout", 32'(dout), 32'(t[0]));
            check("chan_range", 32'(chan_range), 32'(rng[2 * i +: 2]));
            check("mux_chan", 32'(mux_chan), 32'(i));
            rd(`SAR_ADDR_LSB, lsb[rng[2 * i +: 2]], 32'hFFFF_FFFF,
                `AXI_RESP_OKAY);
            rd(`SAR_ADDR_RESULT, {1'b1, 15'h0000, 3'(i),
                (i % 2) ? t : t ^ 13'h1000}, 32'hFFFF_FFFF,
                `AXI_RESP_OKAY);
        end
        wr(`SAR_ADDR_CTRL, 32'h0000_0288);
        for (i = 0; i < 3; i++)
            host_u.frame(13'(i * 100 + 7), 14);
        for (i = 0; i < 3; i++)
            rd(`SAR_ADDR_RESULT, 32'h8000_0000 | 32'(i << 13)
                | 32'(i * 100 + 7), 32'h8000_FFFF, `AXI_RESP_OKAY);
        wr(`SAR_ADDR_CTRL, 32'h0000_0000);
        host_u.frame(13'h0ABC, 5);
        rd(`SAR_ADDR_RESULT, 32'h0, 32'hFFFF_FFFF, `AXI_RESP_OKAY);
        for (i = 0; i < 18; i++)
            host_u.frame(13'(i), 14);
        rd(`SAR_ADDR_STATUS, 32'h0000_0610, 32'h7FF, `AXI_RESP_OKAY);
        wr(`SAR_ADDR_STATUS, 32'h0000_0200);
        rd(`SAR_ADDR_STATUS, 32'h0000_0410, 32'h7FF, `AXI_RESP_OKAY);
        for (i = 0; i < 17; i++)
            rd(`SAR_ADDR_RESULT, 32'h8000_1000 ^ 32'(i), 32'hFFFF_FFFF,
                `AXI_RESP_OKAY);
        rd(`SAR_ADDR_STATUS, 32'h0, 32'h7FF, `AXI_RESP_OKAY);
        repeat (4) @(posedge aclk);
        stop_test();
    end
endmodule // sar_adc_control_config_tb_top

bind sar_adc_control_config sar_ctl_sva chk_u (.aclk, .aresetn,
    .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .sclk,
    .cs_n, .hold, .dac_code, .pd_mode);
